// file: dcc_ahb_mem.sv
`timescale 1ns/1ps
module dcc_ahb_mem (
    input logic pclk,
    input logic presetn,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [63:0] hwdata,
    input logic [3:0] wait_n,
    input logic err_en,
    output logic [63:0] hrdata,
    output logic hready,
    output logic hresp,
    output logic [31:0] seq_q,
    output logic [7:0] wr_cnt,
    output logic [31:0] waddr_q,
    output logic [63:0] wdata_q
);
    logic busy_q;
    logic wr_q;
    logic [31:0] addr_q;
    logic [3:0] cnt_q;
    // Read data tags its own address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy_q, wr_q, hresp, cnt_q, wr_cnt, seq_q} <= '0;
            {hready, hrdata, addr_q, waddr_q, wdata_q} <= {1'b1, 192'h0};
        end else if (!busy_q) begin
            hresp <= 1'b0;
            hready <= 1'b1;
            hrdata <= ~hrdata;
            if (htrans == 2'h2) begin
                busy_q <= 1'b1;
                wr_q <= hwrite;
                addr_q <= haddr;
                cnt_q <= wait_n;
                hready <= wait_n == 4'h0;
                hresp <= err_en;
                hrdata <= {~haddr, haddr};
                seq_q <= {seq_q[30:0], hwrite};
            end
        end else if (!hready) begin
            cnt_q <= cnt_q - 4'h1;
            hready <= cnt_q == 4'h1;
        end else begin
            // Released bus toggles so a late sample cannot pass by luck
            busy_q <= 1'b0;
            hresp <= 1'b0;
            hrdata <= ~hrdata;
            if (wr_q) begin
                wr_cnt <= wr_cnt + 8'h1;
                waddr_q <= addr_q;
                wdata_q <= hwdata;
            end
        end
    end
endmodule // dcc_ahb_mem

// file: dcc_chan.v
`timescale 1ns/1ps
`include "dcc_defs.vh"

module dcc_chan (
    input wire pclk,
    input wire presetn,
    input wire global_enable,
    input wire channel_enable,
    input wire [1:0] input_select,
    input wire sw_trig_wr,
    input wire client_req,
    input wire [15:0] block_transfer_count,
    input wire served,
    input wire block_done,
    input wire bus_err,
    output wire request,
    output wire software_trigger,
    output wire software_trigger_ready,
    output wire [2:0] stop_status,
    output reg kill_q,
    output reg done_q,
    output reg err_q
);

reg en_prev_q;
reg ge_prev_q;
reg pending_q;
reg sw_trig_q;
reg [15:0] remaining_q;
reg [2:0] ss_q;

wire eff_en = channel_enable & global_enable;

assign software_trigger_ready = eff_en & (input_select == `DCC_IS_SW) & ~pending_q &
    ~sw_trig_q & (remaining_q != 16'h0000);
assign request = pending_q & eff_en;
assign software_trigger = sw_trig_q;
assign stop_status = ss_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        en_prev_q <= 1'b0;
        ge_prev_q <= 1'b0;
        pending_q <= 1'b0;
        sw_trig_q <= 1'b0;
        remaining_q <= 16'h0000;
        ss_q <= `DCC_SS_NONE;
        kill_q <= 1'b0;
        done_q <= 1'b0;
        err_q <= 1'b0;
    end else begin
        kill_q <= 1'b0;
        done_q <= 1'b0;
        err_q <= 1'b0;
        en_prev_q <= channel_enable;
        ge_prev_q <= global_enable;
        if (channel_enable & ~en_prev_q) begin
            remaining_q <= block_transfer_count;
            ss_q <= `DCC_SS_NONE;
        end
        if (!channel_enable && !served)
            pending_q <= 1'b0;
        // Accept one cycle after the set, so a disable in between is caught
        if (sw_trig_wr && software_trigger_ready) begin
            sw_trig_q <= 1'b1;
        end else if (sw_trig_q) begin
            sw_trig_q <= 1'b0;
            if (eff_en) begin
                pending_q <= 1'b1;
            end else begin
                err_q <= 1'b1;
                ss_q <= `DCC_SS_DISABLED;
            end
        end
        if (eff_en && input_select == `DCC_IS_HW && client_req && !pending_q && !served &&
            remaining_q != 16'h0000)
            pending_q <= 1'b1;
        if (ge_prev_q && !global_enable && !served) begin
            kill_q <= channel_enable;
            pending_q <= 1'b0;
            if (pending_q) begin
                err_q <= 1'b1;
                ss_q <= `DCC_SS_DISABLED;
            end
        end
        if (bus_err) begin
            pending_q <= 1'b0;
            kill_q <= 1'b1;
            err_q <= 1'b1;
            ss_q <= `DCC_SS_BUSERR;
        end else if (block_done) begin
            pending_q <= 1'b0;
            remaining_q <= remaining_q - 16'h0001;
            if (!global_enable) begin
                kill_q <= 1'b1;
                err_q <= 1'b1;
                ss_q <= `DCC_SS_STOPPED;
            end else if (remaining_q == 16'h0001) begin
                kill_q <= 1'b1;
                done_q <= 1'b1;
                ss_q <= `DCC_SS_DONE;
            end
        end
    end
end

endmodule // dcc_chan

// file: dcc_defs.vh
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets and per-channel register word indices
`define DCC_OFF_GCTRL 8'h00
`define DCC_OFF_FLAGS 8'h04
`define DCC_OFF_CH0 8'h10
`define DCC_OFF_CH1 8'h20
`define DCC_SUB_CFGA 2'h0
`define DCC_SUB_CFGB 2'h1
`define DCC_SUB_SRC 2'h2
`define DCC_SUB_DST 2'h3

////////////////////////////////////////////////////////////////////////////////
// Global control fields
`define DCC_GC_ENABLE 0
`define DCC_GC_HALT 1
`define DCC_GC_STOP 2

// Channel config A fields
`define DCC_A_ENABLE 0
`define DCC_A_SWTRIG 1
`define DCC_A_IS_LO 2
`define DCC_A_NB_LO 4
`define DCC_A_LIM_LO 8
`define DCC_A_ALT 10
`define DCC_A_CNT_LO 16

// Channel config B fields
`define DCC_B_MD_LO 0
`define DCC_B_WD_LO 2
`define DCC_B_READY 4
`define DCC_B_SS_LO 5

////////////////////////////////////////////////////////////////////////////////
// Reset values and encodings
`define DCC_GCTRL_RST 2'h0
`define DCC_CFGA_RST 32'h0000_0000
`define DCC_MODE_BLOCK 2'h0
`define DCC_IS_SW 2'h0
`define DCC_IS_HW 2'h1
`define DCC_SS_NONE 3'h0
`define DCC_SS_BUSERR 3'h1
`define DCC_SS_DISABLED 3'h2
`define DCC_SS_STOPPED 3'h3
`define DCC_SS_DONE 3'h5
`define DCC_HTRANS_IDLE 2'h0
`define DCC_HTRANS_NONSEQ 2'h2

`endif

// file: dcc_top.v
`timescale 1ns/1ps
`include "dcc_defs.vh"

module dcc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] client_transfer_request,
    output reg [31:0] haddr,
    output reg [1:0] htrans,
    output reg hwrite,
    output reg [2:0] hsize,
    output reg [63:0] hwdata,
    input wire [63:0] hrdata,
    input wire hready,
    input wire hresp,
    output reg global_stop_flag
);

localparam S_IDLE = 3'd0;
localparam S_RA = 3'd1;
localparam S_RD = 3'd2;
localparam S_WA = 3'd3;
localparam S_WD = 3'd4;

////////////////////////////////////////////////////////////////////////////////
// State
reg global_enable_q;
reg global_halt_q;
reg [3:0] flags_q;
reg [31:0] cfga_q [0:1];
reg [3:0] cfgb_q [0:1];
reg [31:0] src_q [0:1];
reg [31:0] dst_q [0:1];
reg [1:0] req_s1_q;
reg [1:0] req_s2_q;

reg [2:0] state_q;
reg ch_q;
reg [3:0] nb_q;
reg alt_q;
reg [3:0] step_q;
reg [3:0] rd_idx_q;
reg [3:0] wr_idx_q;
reg [31:0] src_a_q;
reg [31:0] dst_a_q;
reg [63:0] buf_q [0:15];
reg [1:0] bd_q;
reg [1:0] berr_q;

wire [1:0] ch_req;
wire [1:0] ch_swt;
wire [1:0] ch_ready;
wire [1:0] ch_kill;
wire [1:0] ch_done;
wire [1:0] ch_err;
wire [2:0] ch_ss [0:1];
wire [1:0] sw_trig_wr;

////////////////////////////////////////////////////////////////////////////////
// APB decode
wire apb_setup = psel & ~penable;
wire apb_commit = psel & penable & pready;
wire is_gctrl = (paddr == `DCC_OFF_GCTRL);
wire is_flags = (paddr == `DCC_OFF_FLAGS);
wire is_ch0 = (paddr & 8'hf3) == `DCC_OFF_CH0;
wire is_ch1 = (paddr & 8'hf3) == `DCC_OFF_CH1;
wire sel_ch = is_ch1;
wire [1:0] sub = paddr[3:2];
wire mapped = is_gctrl | is_flags | is_ch0 | is_ch1;
// Byte, aligned halfword or full word only
wire strb_ok = (pstrb == 4'h1) | (pstrb == 4'h2) | (pstrb == 4'h4) | (pstrb == 4'h8) |
    (pstrb == 4'h3) | (pstrb == 4'hc) | (pstrb == 4'hf);
wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
wire wr_ok = apb_commit & pwrite & ~pslverr;
wire [31:0] cfga_new = (cfga_q[sel_ch] & ~wmask) | (pwdata & wmask);

assign sw_trig_wr[0] = wr_ok & is_ch0 & (sub == `DCC_SUB_CFGA) & pstrb[0] &
    pwdata[`DCC_A_SWTRIG];
assign sw_trig_wr[1] = wr_ok & is_ch1 & (sub == `DCC_SUB_CFGA) & pstrb[0] &
    pwdata[`DCC_A_SWTRIG];

reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0000_0000;
    if (is_gctrl) begin
        rd_mux[`DCC_GC_ENABLE] = global_enable_q;
        rd_mux[`DCC_GC_HALT] = global_halt_q;
        rd_mux[`DCC_GC_STOP] = global_stop_flag;
    end else if (is_flags) begin
        rd_mux[3:0] = flags_q;
    end else if (is_ch0 | is_ch1) begin
        case (sub)
            `DCC_SUB_CFGA: begin
                rd_mux = cfga_q[sel_ch];
                rd_mux[`DCC_A_SWTRIG] = ch_swt[sel_ch];
            end
            `DCC_SUB_CFGB: begin
                rd_mux[3:0] = cfgb_q[sel_ch];
                rd_mux[`DCC_B_READY] = ch_ready[sel_ch];
                rd_mux[`DCC_B_SS_LO+2:`DCC_B_SS_LO] = ch_ss[sel_ch];
            end
            `DCC_SUB_SRC: rd_mux = src_q[sel_ch];
            default: rd_mux = dst_q[sel_ch];
        endcase
    end
end

// Zero wait states; answer registered in the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= apb_setup;
        if (apb_setup) begin
            pslverr <= ~mapped | (pwrite & ~strb_ok);
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register file
integer i;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        global_enable_q <= 1'b0;
        global_halt_q <= 1'b0;
        global_stop_flag <= 1'b1;
        flags_q <= 4'h0;
        for (i = 0; i < 2; i = i + 1) begin
            cfga_q[i] <= `DCC_CFGA_RST;
            cfgb_q[i] <= {2'h0, `DCC_MODE_BLOCK};
            src_q[i] <= 32'h0000_0000;
            dst_q[i] <= 32'h0000_0000;
        end
    end else begin
        global_stop_flag <= ~global_enable_q | global_halt_q;
        if (wr_ok & is_gctrl & pstrb[0]) begin
            global_enable_q <= pwdata[`DCC_GC_ENABLE];
            global_halt_q <= pwdata[`DCC_GC_HALT];
        end
        // Set wins over a write-one clear in the same cycle
        flags_q <= (flags_q & ~((wr_ok & is_flags & pstrb[0]) ? pwdata[3:0] : 4'h0)) |
            {ch_err, ch_done};
        if (wr_ok & (is_ch0 | is_ch1)) begin
            case (sub)
                `DCC_SUB_CFGA: cfga_q[sel_ch] <= cfga_new;
                `DCC_SUB_CFGB: if (pstrb[0]) cfgb_q[sel_ch] <= pwdata[3:0];
                `DCC_SUB_SRC: src_q[sel_ch] <= (src_q[sel_ch] & ~wmask) | (pwdata & wmask);
                default: dst_q[sel_ch] <= (dst_q[sel_ch] & ~wmask) | (pwdata & wmask);
            endcase
        end
        // Engine write-back keeps the position so a halted transfer resumes there
        if (bd_q != 2'b00) begin
            src_q[ch_q] <= src_a_q;
            dst_q[ch_q] <= dst_a_q;
        end
        for (i = 0; i < 2; i = i + 1)
            if (ch_kill[i])
                cfga_q[i][`DCC_A_ENABLE] <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Client request synchronisers and channel control
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        req_s1_q <= 2'b00;
        req_s2_q <= 2'b00;
    end else begin
        req_s1_q <= client_transfer_request;
        req_s2_q <= req_s1_q;
    end
end

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
        dcc_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .global_enable(global_enable_q),
            .channel_enable(cfga_q[g][`DCC_A_ENABLE]),
            .input_select(cfga_q[g][`DCC_A_IS_LO+1:`DCC_A_IS_LO]),
            .sw_trig_wr(sw_trig_wr[g]),
            .client_req(req_s2_q[g]),
            .block_transfer_count(cfga_q[g][`DCC_A_CNT_LO+15:`DCC_A_CNT_LO]),
            .served((state_q != S_IDLE) && (ch_q == g)),
            .block_done(bd_q[g]),
            .bus_err(berr_q[g]),
            .request(ch_req[g]),
            .software_trigger(ch_swt[g]),
            .software_trigger_ready(ch_ready[g]),
            .stop_status(ch_ss[g]),
            .kill_q(ch_kill[g]),
            .done_q(ch_done[g]),
            .err_q(ch_err[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Block engine, single beats on the AHB master
// Fixed priority: channel 0 wins every arbitration
wire grant_ok = global_enable_q & ~global_halt_q & (ch_req != 2'b00) &
    (bd_q == 2'b00) & (berr_q == 2'b00);
wire grant_ch = ~ch_req[0];
wire [1:0] wd_g = cfgb_q[grant_ch][`DCC_B_WD_LO+1:`DCC_B_WD_LO];
wire [1:0] wd_c = cfgb_q[ch_q][`DCC_B_WD_LO+1:`DCC_B_WD_LO];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_q <= S_IDLE;
        ch_q <= 1'b0;
        nb_q <= 4'h0;
        alt_q <= 1'b0;
        step_q <= 4'h1;
        rd_idx_q <= 4'h0;
        wr_idx_q <= 4'h0;
        src_a_q <= 32'h0000_0000;
        dst_a_q <= 32'h0000_0000;
        bd_q <= 2'b00;
        berr_q <= 2'b00;
        haddr <= 32'h0000_0000;
        htrans <= `DCC_HTRANS_IDLE;
        hwrite <= 1'b0;
        hsize <= 3'h0;
        hwdata <= 64'h0;
    end else begin
        bd_q <= 2'b00;
        berr_q <= 2'b00;
        case (state_q)
            S_IDLE: begin
                if (grant_ok) begin
                    ch_q <= grant_ch;
                    nb_q <= cfga_q[grant_ch][`DCC_A_NB_LO+3:`DCC_A_NB_LO];
                    alt_q <= cfga_q[grant_ch][`DCC_A_ALT];
                    step_q <= 4'h1 << wd_g;
                    hsize <= {1'b0, wd_g};
                    rd_idx_q <= 4'h0;
                    wr_idx_q <= 4'h0;
                    src_a_q <= src_q[grant_ch];
                    dst_a_q <= dst_q[grant_ch];
                    haddr <= src_q[grant_ch];
                    hwrite <= 1'b0;
                    htrans <= `DCC_HTRANS_NONSEQ;
                    state_q <= S_RA;
                end
            end
            S_RA: begin
                if (hready) begin
                    htrans <= `DCC_HTRANS_IDLE;
                    src_a_q <= src_a_q + {28'h0, step_q};
                    state_q <= S_RD;
                end
            end
            S_RD: begin
                if (hresp) begin
                    berr_q[ch_q] <= 1'b1;
                    state_q <= S_IDLE;
                end else if (hready) begin
                    buf_q[rd_idx_q] <= hrdata;
                    if (alt_q || rd_idx_q == nb_q) begin
                        hwdata <= rd_idx_q == wr_idx_q ? hrdata : buf_q[wr_idx_q];
                        haddr <= dst_a_q;
                        hwrite <= 1'b1;
                        htrans <= `DCC_HTRANS_NONSEQ;
                        state_q <= S_WA;
                    end else begin
                        rd_idx_q <= rd_idx_q + 4'h1;
                        haddr <= src_a_q;
                        htrans <= `DCC_HTRANS_NONSEQ;
                        state_q <= S_RA;
                    end
                end
            end
            S_WA: begin
                if (hready) begin
                    htrans <= `DCC_HTRANS_IDLE;
                    dst_a_q <= dst_a_q + {28'h0, step_q};
                    state_q <= S_WD;
                end
            end
            S_WD: begin
                if (hresp) begin
                    berr_q[ch_q] <= 1'b1;
                    state_q <= S_IDLE;
                end else if (hready) begin
                    wr_idx_q <= wr_idx_q + 4'h1;
                    if (wr_idx_q == nb_q) begin
                        hwrite <= 1'b0;
                        bd_q[ch_q] <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (alt_q) begin
                        rd_idx_q <= rd_idx_q + 4'h1;
                        haddr <= src_a_q;
                        hwrite <= 1'b0;
                        htrans <= `DCC_HTRANS_NONSEQ;
                        state_q <= S_RA;
                    end else begin
                        hwdata <= buf_q[wr_idx_q + 4'h1];
                        haddr <= dst_a_q;
                        htrans <= `DCC_HTRANS_NONSEQ;
                        state_q <= S_WA;
                    end
                end
            end
            default: state_q <= S_IDLE;
        endcase
        if (state_q == S_IDLE && !grant_ok)
            hsize <= {1'b0, wd_c};
    end
end

endmodule // dcc_top

// file: dcc_top_sva.sv
`timescale 1ns/1ps
module dcc_top_sva (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [1:0] client_transfer_request,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [63:0] hwdata,
    input logic [63:0] hrdata,
    input logic hready,
    input logic hresp,
    input logic global_stop_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [1:0] gc_q;
    logic en_seen_q;
    logic [4:0] bal_q;
    wire acc = psel && penable && pready;
    wire strb_ok = pstrb inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    wire mapped = paddr[1:0] == 2'h0 && (paddr[7:3] == 5'h0 || paddr[7:4] == 4'h1
        || paddr[7:4] == 4'h2);
    wire en_seen = en_seen_q || gc_q[0];
    wire beat_ok = htrans == 2'h2 && hready;
    // Shadow of the global bits and of reads still owed a write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gc_q <= 2'h0;
            en_seen_q <= 1'b0;
            bal_q <= 5'h0;
        end else begin
            if (acc && pwrite && paddr == 8'h00 && pstrb[0] && strb_ok) begin
                gc_q <= pwdata[1:0];
            end
            en_seen_q <= en_seen;
            if (beat_ok) begin
                bal_q <= hwrite ? bal_q - 5'h1 : bal_q + 5'h1;
            end
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_beat;
        beat_ok;
    endsequence
    a_ready_next: assert property (s_setup ##1 s_access |-> pready)
        else $error("no ready in access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_bad_strobe: assert property (acc && pwrite && !strb_ok |-> pslverr)
        else $error("illegal write size accepted");
    a_good_write: assert property (acc && pwrite && strb_ok && mapped |-> !pslverr)
        else $error("legal write refused");
    a_unmapped_rd: assert property (acc && !pwrite && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_stop_flag: assert property (global_stop_flag == $past(!gc_q[0] || gc_q[1]))
        else $error("stop flag wrong");
    a_idle_off: assert property (!en_seen |-> htrans == 2'h0)
        else $error("bus traffic while disabled");
    a_write_owed: assert property (beat_ok && hwrite |-> bal_q != 5'h0)
        else $error("write without a read before it");
    a_single_beat: assert property (s_beat |=> htrans == 2'h0)
        else $error("beat not single");
    a_beat_hold: assert property (s_beat ##1 !hready |-> $stable(haddr) && $stable(hwdata))
        else $error("beat changed in data phase");
endmodule // dcc_top_sva

bind dcc_top dcc_top_sva u_dcc_top_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .client_transfer_request(client_transfer_request),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hready(hready), .hresp(hresp), .global_stop_flag(global_stop_flag)
);

// file: dma_channel_control_bench.sv
`timescale 1ns/1ps
module dma_channel_control_bench;
    typedef struct packed {
        logic [7:0] a;
        logic [3:0] s;
        logic we;
        logic re;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] x;
    } dcc_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0, wait_n = 4'h0;
    logic [1:0] client_transfer_request = 2'h0;
    logic err_en = 1'b0;
    wire [31:0] prdata, haddr, seq_q, waddr_q;
    wire [63:0] hwdata, hrdata, wdata_q;
    wire [7:0] wr_cnt;
    wire [2:0] hsize;
    wire [1:0] htrans;
    wire pready, pslverr, hwrite, hready, hresp, global_stop_flag;
    integer err_count = 0, compares = 0;
    logic [31:0] q;
    logic er;
    logic [7:0] w0;
    dcc_row_t rows [7];
    dcc_top u_dcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .client_transfer_request(client_transfer_request),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hrdata(hrdata), .hready(hready), .hresp(hresp), .global_stop_flag(global_stop_flag));
    dcc_ahb_mem u_dcc_ahb_mem (.pclk(pclk), .presetn(presetn), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .wait_n(wait_n), .err_en(err_en), .hrdata(hrdata),
        .hready(hready), .hresp(hresp), .seq_q(seq_q), .wr_cnt(wr_cnt), .waddr_q(waddr_q),
        .wdata_q(wdata_q));
    initial begin
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] rq, output logic re);
        integer n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            err_count++;
            wrap_up();
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf, q, er);
        chk({31'h0, er}, 32'h0);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'h0, q, er);
        chk(q & m, x);
    endtask
    task automatic wait_wr(input logic [7:0] n);
        integer k;
        k = 0;
        while (wr_cnt !== n && k < 400) begin
            k++;
            @(posedge pclk);
        end
        if (k == 400) begin
            err_count++;
            wrap_up();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{8'h18, 4'hf, 1'b0, 1'b0, 32'h12345678, 32'hffffffff, 32'h12345678};
        rows[1] = '{8'h18, 4'h1, 1'b0, 1'b0, 32'haaaaaaaa, 32'hffffffff, 32'h123456aa};
        rows[2] = '{8'h18, 4'hc, 1'b0, 1'b0, 32'hbbbbbbbb, 32'hffffffff, 32'hbbbb56aa};
        rows[3] = '{8'h18, 4'h5, 1'b1, 1'b0, 32'h0, 32'hffffffff, 32'hbbbb56aa};
        rows[4] = '{8'h08, 4'hf, 1'b1, 1'b1, 32'hffffffff, 32'hffffffff, 32'h0};
        rows[5] = '{8'h14, 4'hf, 1'b0, 1'b0, 32'h1, 32'h3, 32'h1};
        rows[6] = '{8'h14, 4'h3, 1'b0, 1'b0, 32'h8, 32'hf, 32'h8};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, global_stop_flag}, 32'h1);
        rc(8'h00, 32'hffffffff, 32'h4);
        rc(8'h14, 32'h3, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s, q, er);
            chk({31'h0, er}, {31'h0, rows[i].we});
            apb(1'b0, rows[i].a, 32'h0, 4'h0, q, er);
            chk({31'h0, er}, {31'h0, rows[i].re});
            chk(q & rows[i].m, rows[i].x);
        end
        // Software block, three reads then three writes
        wr(8'h00, 32'h1);
        wr(8'h18, 32'h100);
        wr(8'h1c, 32'h200);
        wr(8'h10, 32'h00010021);
        repeat (5) @(posedge pclk);
        w0 = wr_cnt;
        wr(8'h10, 32'h00010023);
        wait_wr(w0 + 8'h3);
        chk(seq_q & 32'h3f, 32'h07);
        chk(waddr_q, 32'h208);
        chk(wdata_q[31:0], 32'h108);
        repeat (4) @(posedge pclk);
        rc(8'h04, 32'hf, 32'h1);
        rc(8'h14, 32'he0, 32'ha0);
        wr(8'h04, 32'h1);
        rc(8'h04, 32'hf, 32'h0);
        // Client request, two blocks of read/write pairs, slow memory
        wait_n <= 4'h2;
        wr(8'h24, 32'hc);
        wr(8'h28, 32'h300);
        wr(8'h2c, 32'h400);
        wr(8'h20, 32'h00020415);
        w0 = wr_cnt;
        client_transfer_request <= 2'h2;
        wait_wr(w0 + 8'h4);
        repeat (20) @(posedge pclk);
        client_transfer_request <= 2'h0;
        chk({24'h0, wr_cnt}, {24'h0, w0 + 8'h4});
        chk(seq_q & 32'hff, 32'h55);
        chk(waddr_q, 32'h418);
        chk({29'h0, hsize}, 32'h3);
        rc(8'h04, 32'hf, 32'h2);
        wr(8'h04, 32'hf);
        // Halt holds a triggered block back until released
        wait_n <= 4'h0;
        wr(8'h00, 32'h3);
        repeat (2) @(posedge pclk);
        chk({31'h0, global_stop_flag}, 32'h1);
        wr(8'h10, 32'h00010401);
        repeat (5) @(posedge pclk);
        w0 = wr_cnt;
        wr(8'h10, 32'h00010403);
        repeat (30) @(posedge pclk);
        chk({24'h0, wr_cnt}, {24'h0, w0});
        wr(8'h00, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, global_stop_flag}, 32'h0);
        wait_wr(w0 + 8'h1);
        wr(8'h04, 32'hf);
        // Trigger on a disabled channel, then a bus error
        wr(8'h10, 32'h2);
        rc(8'h10, 32'h3, 32'h0);
        err_en <= 1'b1;
        wr(8'h10, 32'h00010001);
        repeat (5) @(posedge pclk);
        wr(8'h10, 32'h00010003);
        repeat (20) @(posedge pclk);
        err_en <= 1'b0;
        rc(8'h04, 32'hf, 32'h4);
        rc(8'h14, 32'he0, 32'h20);
        wr(8'h04, 32'hf);
        // Global disable mid block, second channel waiting behind it
        wait_n <= 4'h4;
        wr(8'h10, 32'h00020031);
        wr(8'h20, 32'h00010001);
        repeat (5) @(posedge pclk);
        w0 = wr_cnt;
        wr(8'h10, 32'h00020033);
        wr(8'h20, 32'h00010003);
        repeat (6) @(posedge pclk);
        wr(8'h00, 32'h0);
        wait_wr(w0 + 8'h4);
        repeat (10) @(posedge pclk);
        chk({24'h0, wr_cnt}, {24'h0, w0 + 8'h4});
        rc(8'h04, 32'hf, 32'hc);
        rc(8'h14, 32'he0, 32'h60);
        rc(8'h24, 32'he0, 32'h40);
        wr(8'h04, 32'hf);
        wr(8'h00, 32'h1);
        wr(8'h20, 32'h00010005);
        wr(8'h00, 32'h0);
        @(posedge pclk);
        rc(8'h20, 32'h1, 32'h0);
        rc(8'h04, 32'hf, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(8'h00, 32'hffffffff, 32'h4);
        wrap_up();
    end
endmodule // dma_channel_control_bench
